/* File: windowed_watchdog_top.v */
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "windowed_watchdog_consts.vh"

module windowed_watchdog_top #(
  parameter PSC_WIDTH = 18,
  parameter TMR_WIDTH = 5
) (
  // Clock, reset, enable
  input  wire        CLK_SYS_IN,
  input  wire        RST_IN,
  input  wire        CE_IN,
  // Avalon-MM slave, word addressed
  input  wire [8:0]  AVS_ADDRESS_IN,
  input  wire        AVS_READ_IN,
  input  wire        AVS_WRITE_IN,
  input  wire [31:0] AVS_WRITEDATA_IN,
  input  wire [3:0]  AVS_BYTEENABLE_IN,
  output wire [31:0] AVS_READDATA_OUT,
  output wire        AVS_WAITREQUEST_OUT,
  output wire [1:0]  AVS_RESPONSE_OUT,
  // Configuration word bits, static
  input  wire [2:0]  WIN_CFG_IN,
  input  wire [4:0]  PER_CFG_IN,
  input  wire [2:0]  CLK_CFG_IN,
  input  wire [1:0]  MODE_CFG_IN,
  // Core events, same clock
  input  wire        CLEAR_CMD_IN,
  input  wire        SLEEP_IN,
  input  wire        OST_RUN_IN,
  input  wire        OSC_FAIL_IN,
  // Oscillator pins, asynchronous
  input  wire        LFINT_OSC_IN,
  input  wire        MFINT_OSC_IN,
  input  wire        EXT_OSC_IN,
  // Watchdog events
  output wire        RESET_REQ_OUT,
  output wire        WAKE_OUT,
  output wire        WIN_VIOL_CLR_OUT,
  output wire        WDT_RST_FLAG_OUT,
  output wire        EXPIRY_EVT_OUT,
  output wire        ENABLED_OUT
);

  localparam [PSC_WIDTH-1:0] PSC_ONE  = {{(PSC_WIDTH-1){1'b0}}, 1'b1};
  localparam [TMR_WIDTH-1:0] TMR_ONE  = {{(TMR_WIDTH-1){1'b0}}, 1'b1};
  localparam [TMR_WIDTH-1:0] TMR_LAST = {TMR_WIDTH{1'b1}};

  // Software visible state
  reg [4:0]           ps_reg;
  reg                 sen_reg;
  reg [2:0]           cs_reg;
  reg [2:0]           win_reg;
  reg                 armed_reg;
  reg [PSC_WIDTH-1:0] psc_reg;
  reg [TMR_WIDTH-1:0] tmr_reg;

  // Bus slave state
  reg [31:0]          rdata_reg;
  reg                 wait_reg;
  reg [1:0]           resp_reg;

  // Oscillator synchronisers and filtered levels
  reg [2:0]           osc_s1_reg;
  reg [2:0]           osc_s2_reg;
  reg [2:0]           osc_s3_reg;
  reg [2:0]           osc_filt_reg;
  reg [2:0]           osc_filt_next;

  // Event outputs and edge trackers
  reg                 rst_req_reg;
  reg                 wake_reg;
  reg                 viol_reg;
  reg                 rflag_reg;
  reg                 expiry_reg;
  reg                 en_reg;
  reg                 sleep_d_reg;

  // Bus decode
  wire req        = AVS_READ_IN | AVS_WRITE_IN;
  wire done       = req & ~wait_reg;
  wire wr_done    = done & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
  wire hit_ctrl0  = AVS_ADDRESS_IN == `WINDOWED_WATCHDOG_IDX_CTRL0;
  wire hit_ctrl1  = AVS_ADDRESS_IN == `WINDOWED_WATCHDOG_IDX_CTRL1;
  wire hit_psl    = AVS_ADDRESS_IN == `WINDOWED_WATCHDOG_IDX_PSC_LOW;
  wire hit_psh    = AVS_ADDRESS_IN == `WINDOWED_WATCHDOG_IDX_PSC_HIGH;
  wire hit_tmr    = AVS_ADDRESS_IN == `WINDOWED_WATCHDOG_IDX_TIMER;
  wire mapped     = hit_ctrl0 | hit_ctrl1 | hit_psl | hit_psh | hit_tmr;
  wire wr_ctrl0   = wr_done & hit_ctrl0;
  wire wr_ctrl1   = wr_done & hit_ctrl1;
  wire arm_read   = done & AVS_READ_IN & hit_ctrl0;

  // Write locks taken from the configuration bits
  wire ps_soft    = PER_CFG_IN == `WINDOWED_WATCHDOG_PS_CFG_SOFT;
  wire cs_soft    = CLK_CFG_IN == `WINDOWED_WATCHDOG_CS_CFG_SOFT;
  wire win_soft   = WIN_CFG_IN == `WINDOWED_WATCHDOG_WIN_CFG_SOFT;

  // Effective window: field only when the configuration leaves it free
  wire [2:0] win_eff = win_soft ? win_reg : WIN_CFG_IN;
  wire       windowed = win_eff != `WINDOWED_WATCHDOG_WIN_FULL;

  // Closed while timer bits 7:3 sit below four times (7 - code)
  wire [2:0] win_gap   = `WINDOWED_WATCHDOG_WIN_FULL - win_eff;
  wire [4:0] win_limit = {win_gap, 2'b00};
  wire       win_open  = ~windowed | (tmr_reg >= win_limit);

  // Enable by operating mode; sleep only matters in mode 10
  reg        enabled;
  always @* begin
    case (MODE_CFG_IN)
      `WINDOWED_WATCHDOG_MODE_ALWAYS:  enabled = 1'b1;
      `WINDOWED_WATCHDOG_MODE_NOSLEEP: enabled = ~SLEEP_IN;
      `WINDOWED_WATCHDOG_MODE_SOFT:    enabled = sen_reg;
      default:            enabled = 1'b0;
    endcase
  end

  // Clear command outcome; in windowed mode, unarmed or closed window is a violation
  wire clr_viol  = CLEAR_CMD_IN & windowed &
                   (~armed_reg | ~win_open);
  wire clr_valid = CLEAR_CMD_IN & ~clr_viol;

  // Sleep edges; waking by any cause clears the counter
  wire sleep_enter = SLEEP_IN & ~sleep_d_reg;
  wire sleep_exit  = ~SLEEP_IN & sleep_d_reg;

  // Every condition besides reset that holds the counters at zero
  wire cnt_clear = clr_valid | sleep_enter | sleep_exit |
                   ~enabled | OST_RUN_IN | OSC_FAIL_IN |
                   wr_ctrl0 | wr_ctrl1;

  // Oscillator pins pass three flops; a level counts once s2 and s3 agree
  always @* begin
    osc_filt_next = osc_filt_reg;
    if (osc_s2_reg[0] == osc_s3_reg[0]) osc_filt_next[0] = osc_s3_reg[0];
    if (osc_s2_reg[1] == osc_s3_reg[1]) osc_filt_next[1] = osc_s3_reg[1];
    if (osc_s2_reg[2] == osc_s3_reg[2]) osc_filt_next[2] = osc_s3_reg[2];
  end

  wire [2:0] osc_rise = osc_filt_next & ~osc_filt_reg;

  // Selected counting clock; reserved codes give no ticks
  reg osc_tick;
  always @* begin
    case (cs_reg)
      `WINDOWED_WATCHDOG_CS_LFINT: osc_tick = osc_rise[0];
      `WINDOWED_WATCHDOG_CS_MFINT: osc_tick = osc_rise[1];
      `WINDOWED_WATCHDOG_CS_EXT:   osc_tick = osc_rise[2];
      default:        osc_tick = 1'b0;
    endcase
  end

  // Prescale code: timer steps every 2^code ticks, 32 steps a period
  wire [4:0] ps_eff = (ps_reg > `WINDOWED_WATCHDOG_PS_MAX) ? 5'h00 : ps_reg;
  wire [PSC_WIDTH-1:0] psc_mask = (PSC_ONE << ps_eff) - PSC_ONE;
  wire psc_wrap  = (psc_reg & psc_mask) == psc_mask;
  wire tmr_step  = osc_tick & psc_wrap;
  wire time_out  = tmr_step & (tmr_reg == TMR_LAST);

  // Synchronisers; the first stage feeds only the second
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      osc_s1_reg   <= 3'h0;
      osc_s2_reg   <= 3'h0;
      osc_s3_reg   <= 3'h0;
      osc_filt_reg <= 3'h0;
    end else if (CE_IN) begin
      osc_s1_reg   <= {EXT_OSC_IN, MFINT_OSC_IN, LFINT_OSC_IN};
      osc_s2_reg   <= osc_s1_reg;
      osc_s3_reg   <= osc_s2_reg;
      osc_filt_reg <= osc_filt_next;
    end
  end

  // Prescaler and window counter; reset clears both
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      psc_reg <= {PSC_WIDTH{1'b0}};
      tmr_reg <= {TMR_WIDTH{1'b0}};
    end else if (CE_IN) begin
      if (cnt_clear) begin
        psc_reg <= {PSC_WIDTH{1'b0}};
        tmr_reg <= {TMR_WIDTH{1'b0}};
      end else if (osc_tick) begin
        if (psc_wrap) begin
          psc_reg <= {PSC_WIDTH{1'b0}};
          tmr_reg <= tmr_reg + TMR_ONE;                  // Wraps at time-out
        end else begin
          psc_reg <= psc_reg + PSC_ONE;
        end
      end
    end
  end

  // Arming: read of control zero sets, a good clear drops it.
  // The read wins if both land in one cycle so software keeps its arm.
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      armed_reg <= 1'b0;
    end else if (CE_IN) begin
      if (arm_read) begin
        armed_reg <= 1'b1;
      end else if (clr_valid) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // Control fields; reset values follow the configuration word, except the soft enable
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ps_reg  <= ps_soft ? `WINDOWED_WATCHDOG_PS_DEFAULT : PER_CFG_IN;
      cs_reg  <= cs_soft ? `WINDOWED_WATCHDOG_CS_DEFAULT : CLK_CFG_IN;
      win_reg <= WIN_CFG_IN;
      sen_reg <= `WINDOWED_WATCHDOG_SEN_DEFAULT;
    end else if (CE_IN) begin
      if (wr_ctrl0) begin
        sen_reg <= AVS_WRITEDATA_IN[`WINDOWED_WATCHDOG_CTRL0_SEN_BIT];
        if (ps_soft) begin
          ps_reg <= AVS_WRITEDATA_IN[`WINDOWED_WATCHDOG_CTRL0_PS_LSB +: 5];
        end
      end
      if (wr_ctrl1) begin
        if (cs_soft) begin
          cs_reg <= AVS_WRITEDATA_IN[`WINDOWED_WATCHDOG_CTRL1_CS_LSB +: 3];
        end
        if (win_soft) begin
          win_reg <= AVS_WRITEDATA_IN[`WINDOWED_WATCHDOG_CTRL1_WIN_LSB +: 3];
        end
      end
    end
  end

  // Read mux; locked fields read back their effective value
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit_ctrl0) begin
      rd_byte = {2'b00, ps_reg, sen_reg};
    end else if (hit_ctrl1) begin
      rd_byte = {1'b0, cs_reg, 1'b0, win_reg};
    end else if (hit_psl) begin
      rd_byte = psc_reg[7:0];
    end else if (hit_psh) begin
      rd_byte = psc_reg[15:8];
    end else if (hit_tmr) begin
      rd_byte = {tmr_reg, armed_reg, psc_reg[17:16]};
    end
  end

  // One wait state: data is latched, then waitrequest drops for a cycle
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= `WINDOWED_WATCHDOG_RESP_OKAY;
    end else if (CE_IN) begin
      if (req & wait_reg) begin
        wait_reg  <= 1'b0;
        rdata_reg <= {24'h00_0000, rd_byte};
        resp_reg  <= mapped ? `WINDOWED_WATCHDOG_RESP_OKAY : `WINDOWED_WATCHDOG_RESP_SLVERR;
      end else begin
        wait_reg  <= 1'b1;
      end
    end
  end

  // Watchdog events; outputs other than the enable level are single-cycle pulses from flops
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      rst_req_reg <= 1'b0;
      wake_reg    <= 1'b0;
      viol_reg    <= 1'b0;
      rflag_reg   <= 1'b0;
      expiry_reg  <= 1'b0;
      en_reg      <= 1'b0;
      sleep_d_reg <= 1'b0;
    end else if (CE_IN) begin
      sleep_d_reg <= SLEEP_IN;
      en_reg      <= enabled;
      // A violation resets and tells the cause logic to clear its flag
      viol_reg    <= clr_viol;
      // Time-out asleep wakes the core; awake it resets
      wake_reg    <= time_out & ~cnt_clear & SLEEP_IN;
      rst_req_reg <= clr_viol |
                     (time_out & ~cnt_clear & ~SLEEP_IN);
      rflag_reg   <= time_out & ~cnt_clear & ~SLEEP_IN;
      expiry_reg  <= time_out & ~cnt_clear;
    end
  end

  // Output drive, all straight from flops
  assign AVS_READDATA_OUT    = rdata_reg;
  assign AVS_WAITREQUEST_OUT = wait_reg;
  assign AVS_RESPONSE_OUT    = resp_reg;
  assign RESET_REQ_OUT       = rst_req_reg;
  assign WAKE_OUT            = wake_reg;
  assign WIN_VIOL_CLR_OUT    = viol_reg;
  assign WDT_RST_FLAG_OUT    = rflag_reg;
  assign EXPIRY_EVT_OUT      = expiry_reg;
  assign ENABLED_OUT         = en_reg;

endmodule // windowed_watchdog_top

/* File: windowed_watchdog_consts.vh */
`ifndef WINDOWED_WATCHDOG_CONSTS_VH
`define WINDOWED_WATCHDOG_CONSTS_VH

// Register indices; the bus word address equals the index
`define WINDOWED_WATCHDOG_IDX_CTRL0      9'h18c
`define WINDOWED_WATCHDOG_IDX_CTRL1      9'h18d
`define WINDOWED_WATCHDOG_IDX_PSC_LOW    9'h18e
`define WINDOWED_WATCHDOG_IDX_PSC_HIGH   9'h18f
`define WINDOWED_WATCHDOG_IDX_TIMER      9'h190

// Field positions
`define WINDOWED_WATCHDOG_CTRL0_SEN_BIT  0
`define WINDOWED_WATCHDOG_CTRL0_PS_LSB   1
`define WINDOWED_WATCHDOG_CTRL1_WIN_LSB  0
`define WINDOWED_WATCHDOG_CTRL1_CS_LSB   4

// Reset values and special configuration codes
`define WINDOWED_WATCHDOG_PS_DEFAULT     5'h0b
`define WINDOWED_WATCHDOG_PS_CFG_SOFT    5'h1f
`define WINDOWED_WATCHDOG_PS_MAX         5'h12
`define WINDOWED_WATCHDOG_CS_DEFAULT     3'h0
`define WINDOWED_WATCHDOG_CS_CFG_SOFT    3'h7
`define WINDOWED_WATCHDOG_WIN_CFG_SOFT   3'h7
`define WINDOWED_WATCHDOG_WIN_FULL       3'h7
`define WINDOWED_WATCHDOG_SEN_DEFAULT    1'h0

// Clock select codes
`define WINDOWED_WATCHDOG_CS_LFINT       3'h0
`define WINDOWED_WATCHDOG_CS_MFINT       3'h1
`define WINDOWED_WATCHDOG_CS_EXT         3'h3

// Operating mode codes
`define WINDOWED_WATCHDOG_MODE_OFF       2'h0
`define WINDOWED_WATCHDOG_MODE_SOFT      2'h1
`define WINDOWED_WATCHDOG_MODE_NOSLEEP   2'h2
`define WINDOWED_WATCHDOG_MODE_ALWAYS    2'h3

// Avalon response codes
`define WINDOWED_WATCHDOG_RESP_OKAY      2'h0
`define WINDOWED_WATCHDOG_RESP_SLVERR    2'h2

`endif

/* File: windowed_watchdog_checker.sv */
`timescale 1ns/1ps
module windowed_watchdog_checker (
  // Clock and reset
  input wire       CLK_SYS_IN,
  input wire       RST_IN,
  // Core events and configuration
  input wire [1:0] MODE_CFG_IN,
  input wire       SLEEP_IN,
  input wire       OST_RUN_IN,
  input wire       OSC_FAIL_IN,
  // Watchdog events
  input wire       RESET_REQ_OUT,
  input wire       WAKE_OUT,
  input wire       WIN_VIOL_CLR_OUT,
  input wire       WDT_RST_FLAG_OUT,
  input wire       EXPIRY_EVT_OUT,
  input wire       ENABLED_OUT
);
  // One domain, so one clock and one reset for every property
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  // Event outputs must agree with each other and with the core state
  property p_viol; WIN_VIOL_CLR_OUT |-> RESET_REQ_OUT; endproperty
  a_viol: assert property (p_viol) else $error("lone violation");
  property p_cause;
    RESET_REQ_OUT |-> WIN_VIOL_CLR_OUT || WDT_RST_FLAG_OUT;
  endproperty
  a_cause: assert property (p_cause) else $error("reset lacks cause");
  property p_flag;
    WDT_RST_FLAG_OUT |-> RESET_REQ_OUT && EXPIRY_EVT_OUT && !$past(SLEEP_IN);
  endproperty
  a_flag: assert property (p_flag) else $error("bad expiry reset");
  property p_wake;
    WAKE_OUT |-> EXPIRY_EVT_OUT && !RESET_REQ_OUT && $past(SLEEP_IN);
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake event");
  // A clearing cause at an edge suppresses a time-out from that edge
  property p_ost; OST_RUN_IN |=> !EXPIRY_EVT_OUT; endproperty
  a_ost: assert property (p_ost) else $error("expiry in start-up");
  property p_fail; OSC_FAIL_IN |=> !EXPIRY_EVT_OUT; endproperty
  a_fail: assert property (p_fail) else $error("expiry on fail");
  property p_sleep; $changed(SLEEP_IN) |=> !EXPIRY_EVT_OUT; endproperty
  a_sleep: assert property (p_sleep) else $error("expiry at sleep");
  // Release edge excluded: the enable flop still holds its reset value
  property p_mode;
    !RST_IN && MODE_CFG_IN[1] == MODE_CFG_IN[0] |=>
      ENABLED_OUT == MODE_CFG_IN[1];
  endproperty
  a_mode: assert property (p_mode) else $error("enable vs mode");
  property p_dis; !ENABLED_OUT [*2] |-> !EXPIRY_EVT_OUT; endproperty
  a_dis: assert property (p_dis) else $error("expiry while off");

  // Main scenarios reached
  c_rst: cover property (WDT_RST_FLAG_OUT);
  c_wake: cover property (WAKE_OUT);
  c_viol: cover property (WIN_VIOL_CLR_OUT);
endmodule // windowed_watchdog_checker

bind windowed_watchdog_top windowed_watchdog_checker u_chk (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .MODE_CFG_IN(MODE_CFG_IN),
  .SLEEP_IN(SLEEP_IN), .OST_RUN_IN(OST_RUN_IN), .OSC_FAIL_IN(OSC_FAIL_IN),
  .RESET_REQ_OUT(RESET_REQ_OUT), .WAKE_OUT(WAKE_OUT),
  .WIN_VIOL_CLR_OUT(WIN_VIOL_CLR_OUT), .WDT_RST_FLAG_OUT(WDT_RST_FLAG_OUT),
  .EXPIRY_EVT_OUT(EXPIRY_EVT_OUT), .ENABLED_OUT(ENABLED_OUT));

/* File: test_windowed_watchdog_timer.sv */
`timescale 1ns/1ps
module test_windowed_watchdog_timer;
  // Stimulus, observed outputs and bookkeeping
  logic        clk = 1'h0, rst = 1'h1, osc = 1'h0, clr = 1'h0, ce = 1'h1;
  logic        slp = 1'h0, oscillator_startup_timer = 1'h0, fail = 1'h0, rd = 1'h0, wr = 1'h0;
  logic [8:0]  adr = 9'h000;
  logic [7:0]  wd = 8'h00, q;
  logic [31:0] rdat;
  logic [1:0]  resp, r, mcfg = 2'h1;
  logic [2:0]  wcfg = 3'h7, ccfg = 3'h7;
  logic [4:0]  pcfg = 5'h1f;
  logic        wait_q, rreq, wake, viol, flag, expv, ena;
  logic [31:0] cnt [5] = '{default: 32'h0};
  logic [31:0] bas [5];
  int          err_total = 0, cmp_count = 0;

  windowed_watchdog_top dut (
    .CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN({24'h000000, wd}), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wait_q),
    .AVS_RESPONSE_OUT(resp), .WIN_CFG_IN(wcfg), .PER_CFG_IN(pcfg),
    .CLK_CFG_IN(ccfg), .MODE_CFG_IN(mcfg), .CLEAR_CMD_IN(clr),
    .SLEEP_IN(slp), .OST_RUN_IN(oscillator_startup_timer), .OSC_FAIL_IN(fail),
    .LFINT_OSC_IN(osc), .MFINT_OSC_IN(osc), .EXT_OSC_IN(~osc),
    .RESET_REQ_OUT(rreq), .WAKE_OUT(wake), .WIN_VIOL_CLR_OUT(viol),
    .WDT_RST_FLAG_OUT(flag), .EXPIRY_EVT_OUT(expv), .ENABLED_OUT(ena));

  // System clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end
  // Slow oscillator: one tick every eight system cycles
  always begin
    repeat (4) @(posedge clk);
    osc <= ~osc;
  end
  // Pulse counters, paused in reset so power-up unknowns are not summed;
  // an unknown output after reset still poisons its count
  always @(posedge clk) begin
    if (!rst) begin
      cnt[0] <= cnt[0] + rreq;
      cnt[1] <= cnt[1] + wake;
      cnt[2] <= cnt[2] + viol;
      cnt[3] <= cnt[3] + flag;
      cnt[4] <= cnt[4] + expv;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_q !== 1'h0);
    // Only the bench watchdog ends a stuck wait; one wait state expected
    chk(n, 32'h2);
    q = rdat[7:0];
    r = resp;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task rchk(input logic [8:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk({q, r}, {e, 2'h0});
  endtask
  task pulse;
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // Pulses since last call; mask order is reset, wake, viol, flag, expiry
  task ev(input logic [4:0] e);
    for (int i = 0; i < 5; i++) begin
      chk(cnt[i] - bas[i], {31'h0, e[4-i]});
      bas[i] = cnt[i];
    end
  endtask
  task reset_dut(input logic [2:0] w, input logic [4:0] p,
                 input logic [2:0] c, input logic [1:0] m);
    rst <= 1'h1;
    wcfg <= w;
    pcfg <= p;
    ccfg <= c;
    mcfg <= m;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    bas = cnt;
  endtask
  task give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog on the bench itself; the tests need under 6000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict;
  end

  // Main sequence
  initial begin
    reset_dut(3'h7, 5'h1f, 3'h7, 2'h1);
    rchk(9'h190, 8'h00);
    rchk(9'h18e, 8'h00);
    rchk(9'h18f, 8'h00);
    rchk(9'h18c, 8'h16);
    rchk(9'h18d, 8'h07);
    bus(1'h0, 9'h1a0, 8'h00);
    chk({q, r}, 10'h002);
    bus(1'h1, 9'h18c, 8'h01);
    rchk(9'h18c, 8'h01);
    chk({31'h0, ena}, 32'h1);
    repeat (400) @(posedge clk);
    ev(5'h13);
    // Armed clear while the window is still closed
    bus(1'h1, 9'h18d, 8'h06);
    rchk(9'h18c, 8'h01);
    bus(1'h0, 9'h190, 8'h00);
    chk({31'h0, q[2]}, 32'h1);
    pulse;
    ev(5'h14);
    // Armed clear in the open part, then an unarmed one; external clock
    bus(1'h1, 9'h18d, 8'h36);
    rchk(9'h18d, 8'h36);
    repeat (60) @(posedge clk);
    rchk(9'h18c, 8'h01);
    pulse;
    ev(5'h00);
    bus(1'h0, 9'h190, 8'h00);
    chk({q[7:4], q[2]}, 5'h00);
    repeat (60) @(posedge clk);
    pulse;
    ev(5'h14);
    // Full window and second clock source
    bus(1'h1, 9'h18d, 8'h17);
    rchk(9'h18d, 8'h17);
    pulse;
    ev(5'h00);
    // Clock enable low freezes the counter past a whole period
    ce <= 1'h0;
    repeat (400) @(posedge clk);
    ce <= 1'h1;
    ev(5'h00);
    slp <= 1'h1;
    repeat (400) @(posedge clk);
    slp <= 1'h0;
    ev(5'h09);
    oscillator_startup_timer <= 1'h1;
    repeat (400) @(posedge clk);
    oscillator_startup_timer <= 1'h0;
    fail <= 1'h1;
    repeat (400) @(posedge clk);
    fail <= 1'h0;
    ev(5'h00);
    bus(1'h1, 9'h18c, 8'h00);
    // Enable flop follows the new soft enable one edge later
    repeat (2) @(posedge clk);
    chk({31'h0, ena}, 32'h0);
    repeat (400) @(posedge clk);
    ev(5'h00);
    // Fields locked by configuration; mode always on
    reset_dut(3'h2, 5'h03, 3'h1, 2'h3);
    rchk(9'h18c, 8'h06);
    bus(1'h1, 9'h18c, 8'h3f);
    bus(1'h1, 9'h18d, 8'h77);
    rchk(9'h18c, 8'h07);
    rchk(9'h18d, 8'h12);
    chk({31'h0, ena}, 32'h1);
    pulse;
    ev(5'h14);
    // Off while asleep, on while awake
    reset_dut(3'h7, 5'h1f, 3'h7, 2'h2);
    bus(1'h1, 9'h18c, 8'h00);
    slp <= 1'h1;
    repeat (400) @(posedge clk);
    chk({31'h0, ena}, 32'h0);
    slp <= 1'h0;
    repeat (300) @(posedge clk);
    ev(5'h13);
    reset_dut(3'h7, 5'h1f, 3'h7, 2'h0);
    bus(1'h1, 9'h18c, 8'h01);
    repeat (2) @(posedge clk);
    chk({31'h0, ena}, 32'h0);
    give_verdict;
  end
endmodule // test_windowed_watchdog_timer
